// ==== rtl/pcsi_params.svh ====
`ifndef PCSI_PARAMS_SVH
`define PCSI_PARAMS_SVH
// Program counter and stack geometry
`define PCSI_PC_W 13
`define PCSI_LOW_W 8
`define PCSI_HIGH_W 5
`define PCSI_JUMP_W 11
`define PCSI_STACK_DEPTH 8
`define PCSI_SP_W 3
// Data addressing
`define PCSI_DADDR_W 9
`define PCSI_DATA_W 8
// Register offsets on the software port
`define PCSI_REG_PC_LOW 3'h0
`define PCSI_REG_PTR 3'h1
`define PCSI_REG_LATCH 3'h2
`define PCSI_REG_PC_HIGH_STAT 3'h3
`define PCSI_REG_BANK 3'h4
// Data-space location of the indirect window
`define PCSI_WINDOW_ADDR 8'h00
// Reset values
`define PCSI_PC_RESET 13'h0000
`define PCSI_BYTE_RESET 8'h00
`endif

// ==== rtl/pcsi_pkg.sv ====
package pcsi_pkg;
  // Program-flow operation issued by the execute stage
  typedef enum logic [2:0] {
    PCSI_OP_NONE,
    PCSI_OP_STEP,
    PCSI_OP_CALL,
    PCSI_OP_JUMP,
    PCSI_OP_RETURN,
    PCSI_OP_RET_LIT,
    PCSI_OP_RET_INT,
    PCSI_OP_IRQ
  } pcsi_op_e;
  // Flow request: operation plus jump operand and interrupt vector
  typedef struct packed {
    pcsi_op_e op;
    logic [10:0] target;
    logic [12:0] vector;
  } pcsi_flow_s;
  // Data access request from the execute stage
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcsi_dreq_s;
endpackage

// ==== rtl/pcsi_stack_mem.sv ====
`timescale 1ns/1ps
`include "pcsi_params.svh"
// Return address store; read data registered
module pcsi_stack_mem #(
  parameter int DEPTH = `PCSI_STACK_DEPTH,
  parameter int AW = `PCSI_SP_W,
  parameter int DW = `PCSI_PC_W
) (
  // Clock
  input wire logic core_clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // Storage array, no reset needed
  logic [DW-1:0] mem [DEPTH];

  // Write side
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge core_clk) begin
    rdata <= mem[raddr];
  end
endmodule

// ==== rtl/pcsi_sync3.sv ====
`timescale 1ns/1ps
`include "pcsi_params.svh"
// Three-stage input synchroniser, change taken when stages two and three agree
module pcsi_sync3 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Raw pin and clean level
  input wire logic din,
  output logic dout
);
  // Stage registers
  logic s1;
  logic s2;
  logic s3;

  // Shift chain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule

// ==== rtl/pcsi_core.sv ====
`timescale 1ns/1ps
`include "pcsi_params.svh"
module pcsi_core #(
  parameter int DEPTH = `PCSI_STACK_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Flow requests from execute
  input wire pcsi_pkg::pcsi_flow_s flow,
  // Data access from execute
  input wire pcsi_pkg::pcsi_dreq_s dreq,
  // External bank select pin, asynchronous
  input wire logic bank_pin,
  // Data memory side
  output logic [8:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Read data back to execute
  output logic [7:0] exec_rdata,
  // Current program counter
  output logic [12:0] pc,
  // Software register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // Latch for the upper PC bits
  logic [4:0] pc_high_latch;
  // Indirect pointer
  logic [7:0] indirect_pointer;
  // Bank select bit used for indirect addressing
  logic bank_select_high;
  // Software bank override
  logic bank_sw;
  // Synchronised pin level
  logic bank_sync;
  // Stack pointer, hidden from software
  logic [2:0] sp;
  // Pending pop target
  logic [2:0] sp_dec;
  // Stack memory read data
  logic [12:0] stack_top;
  // Pop waiting for registered stack data
  logic pop_pend;
  // Push control
  logic push;
  logic pop;
  // Window hit decode
  logic win_hit;
  logic self_ref;
  // Pending read-zero return
  logic zero_rd;
  logic fwd_rd;

  // Operation decode
  assign push = (flow.op == pcsi_pkg::PCSI_OP_CALL) || (flow.op == pcsi_pkg::PCSI_OP_IRQ);
  assign pop = (flow.op == pcsi_pkg::PCSI_OP_RETURN) || (flow.op == pcsi_pkg::PCSI_OP_RET_LIT)
    || (flow.op == pcsi_pkg::PCSI_OP_RET_INT);
  assign sp_dec = sp - 3'h1;
  assign bank_select_high = bank_sw | bank_sync;
  assign win_hit = (dreq.addr == `PCSI_WINDOW_ADDR);
  assign self_ref = win_hit && (indirect_pointer == `PCSI_WINDOW_ADDR);

  // Pin synchroniser
  pcsi_sync3 u_bank_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(bank_pin),
    .dout(bank_sync)
  );

  // A push writes at the pointer and a pop reads one below it. A call that is
  // followed at once by a return therefore reads back the entry just written.
  // Return stack storage; circular because pointer simply wraps
  pcsi_stack_mem #(
    .DEPTH(DEPTH)
  ) u_stack (
    .core_clk(core_clk),
    .we(push),
    .waddr(sp),
    .wdata(pc + 13'h0001),
    .raddr(sp_dec), // Top of stack always sits one below the pointer
    .rdata(stack_top)
  );

  // Stack pointer, wraps with no overflow status
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 3'h0;
    end else if (push) begin
      sp <= sp + 3'h1;
    end else if (pop) begin
      sp <= sp_dec;
    end
  end

  // Pop completes when the registered stack data arrive
  // The registered read costs one cycle, so the core leaves an idle op after a return
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pop_pend <= 1'b0;
    end else begin
      pop_pend <= pop;
    end
  end

  // Program counter
  // A low-byte write outranks a pending pop; the core must keep the two apart
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= `PCSI_PC_RESET;
    end else if (reg_wr && reg_addr == `PCSI_REG_PC_LOW) begin
      pc <= {pc_high_latch, reg_wdata};
    end else if (pop_pend) begin
      pc <= stack_top;
    end else begin
      case (flow.op)
        pcsi_pkg::PCSI_OP_STEP: begin
          pc <= pc + 13'h0001;
        end
        pcsi_pkg::PCSI_OP_CALL, pcsi_pkg::PCSI_OP_JUMP: begin
          pc <= {pc_high_latch[4:3], flow.target};
        end
        pcsi_pkg::PCSI_OP_IRQ: begin
          pc <= flow.vector;
        end
        default: begin
          pc <= pc;
        end
      endcase
    end
  end

  // High latch: only software writes touch it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_high_latch <= 5'h00;
    end else if (reg_wr && reg_addr == `PCSI_REG_LATCH) begin
      pc_high_latch <= reg_wdata[4:0];
    end
  end

  // Pointer and bank override
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_pointer <= `PCSI_BYTE_RESET;
      bank_sw <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `PCSI_REG_PTR) begin
        indirect_pointer <= reg_wdata;
      end
      if (reg_wr && reg_addr == `PCSI_REG_BANK) begin
        bank_sw <= reg_wdata[0];
      end
    end
  end

  // Data memory drive with window redirection
  // Idle requests decode as the window too, so the pointer address shows on the bus
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= 9'h000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      zero_rd <= 1'b0;
      fwd_rd <= 1'b0;
    end else begin
      mem_addr <= win_hit ? {bank_select_high, indirect_pointer} : {1'b0, dreq.addr};
      mem_rd <= dreq.rd && !self_ref;
      mem_wr <= dreq.wr && !self_ref;
      mem_wdata <= dreq.wdata;
      zero_rd <= dreq.rd && self_ref;
      fwd_rd <= dreq.rd && !self_ref;
    end
  end

  // Read data return to execute
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_rdata <= 8'h00;
    end else if (zero_rd) begin
      exec_rdata <= 8'h00;
    end else if (fwd_rd) begin
      exec_rdata <= mem_rdata;
    end
  end

  // Register readback; stack pointer never appears
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PCSI_REG_PC_LOW: reg_rdata <= pc[7:0];
        `PCSI_REG_PTR: reg_rdata <= indirect_pointer;
        `PCSI_REG_LATCH: reg_rdata <= {3'h0, pc_high_latch};
        `PCSI_REG_PC_HIGH_STAT: reg_rdata <= {7'h00, pop_pend};
        `PCSI_REG_BANK: reg_rdata <= {7'h00, bank_select_high};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks
  pc_low_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == `PCSI_REG_PC_LOW |=> pc == {$past(pc_high_latch), $past(reg_wdata)})
    else $error("pc low write did not load full pc");
  jump_target_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_wr && !pop_pend && flow.op == pcsi_pkg::PCSI_OP_JUMP |=> pc == {$past(pc_high_latch[4:3]), $past(flow.target)})
    else $error("jump target wrong");
  call_push_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    push |=> sp == $past(sp) + 3'h1)
    else $error("push did not advance pointer");
  pop_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    flow.op == pcsi_pkg::PCSI_OP_CALL && !reg_wr && !pop_pend ##1 flow.op == pcsi_pkg::PCSI_OP_RETURN && !reg_wr
    |=> ##1 pc == $past(pc, 3) + 13'h0001)
    else $error("return address mismatch");
  latch_stable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (push || pop) && !reg_wr |=> $stable(pc_high_latch))
    else $error("latch changed by stack op");
  self_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    dreq.rd && self_ref |=> ##1 exec_rdata == 8'h00)
    else $error("self window read not zero");
  self_nowrite_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    dreq.wr && self_ref |=> !mem_wr)
    else $error("self window write reached memory");
  ind_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    win_hit |=> mem_addr == {$past(bank_select_high), $past(indirect_pointer)})
    else $error("indirect address wrong");

  // Counter and stack checks
  // Plain step advances the counter by one
  step_incr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_wr && !pop_pend && flow.op == pcsi_pkg::PCSI_OP_STEP |=> pc == $past(pc) + 13'h0001)
    else $error("step did not advance pc");
  // Call takes its low eleven bits from the operand
  call_target_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_wr && !pop_pend && flow.op == pcsi_pkg::PCSI_OP_CALL |=> pc[10:0] == $past(flow.target))
    else $error("call target wrong");
  // Interrupt vectoring loads the vector as the new counter
  irq_vector_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_wr && !pop_pend && flow.op == pcsi_pkg::PCSI_OP_IRQ |=> pc == $past(flow.vector))
    else $error("irq vector not loaded");
  // Every pop steps the hidden pointer back, wrapping silently
  pop_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pop |=> sp == $past(sp) - 3'h1)
    else $error("pop did not retreat pointer");

  // Data path checks
  // Direct addresses pass straight through in the lower bank
  direct_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !win_hit |=> mem_addr == {1'b0, $past(dreq.addr)})
    else $error("direct address wrong");
  // Window reads reach memory unless the pointer aims at the window
  win_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    dreq.rd && win_hit && !self_ref |=> mem_rd)
    else $error("window read lost");
  // A self-referencing read never reaches memory
  self_noread_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    dreq.rd && self_ref |=> !mem_rd)
    else $error("self window read reached memory");
  // Forwarded read data are those that memory returned
  read_return_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fwd_rd |=> exec_rdata == $past(mem_rdata))
    else $error("read data not forwarded");

  // Register port checks
  // Low byte reads return the live counter bits
  pcl_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PCSI_REG_PC_LOW |=> reg_rdata == $past(pc[7:0]))
    else $error("pc low readback wrong");
  // Nothing leaks onto the read bus between reads
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside a read");

  // Scenario covers: call, wrap, window, step and self-reference
  call_cov: cover property (@(posedge core_clk) disable iff (!rst_n) flow.op == pcsi_pkg::PCSI_OP_CALL);
  wrap_cov: cover property (@(posedge core_clk) disable iff (!rst_n) push && sp == 3'h7);
  win_cov: cover property (@(posedge core_clk) disable iff (!rst_n) dreq.rd && win_hit && !self_ref);
  step_cov: cover property (@(posedge core_clk) disable iff (!rst_n) flow.op == pcsi_pkg::PCSI_OP_STEP);
  self_cov: cover property (@(posedge core_clk) disable iff (!rst_n) dreq.wr && self_ref);
endmodule

// ==== testbench/pcsi_dmem_model.sv ====
`timescale 1ns/1ps
// Data memory standing behind the indirect addressing logic
module pcsi_dmem_model (
  // Clock
  input wire logic core_clk,
  // Access from the block
  input wire logic [8:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  // Read data back
  output logic [7:0] mem_rdata
);
  // Full nine-bit data space
  logic [7:0] store [512];
  // Last value seen on the read bus
  logic [7:0] last = 8'h00;
  // Store on the write strobe, track the bus for the idle pattern
  always_ff @(posedge core_clk) begin
    if (mem_wr) begin
      store[mem_addr] <= mem_wdata;
    end
    last <= mem_rdata;
  end
  // Outside a read the bus flips every cycle, so stale data never matches
  assign mem_rdata = mem_rd ? store[mem_addr] : ~last;
endmodule

// ==== testbench/program_counter_stack_indirect_tb_top.sv ====
`timescale 1ns/1ps
`include "pcsi_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module program_counter_stack_indirect_tb_top;
  // Stimulus
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pcsi_pkg::pcsi_flow_s flow = '0;
  pcsi_pkg::pcsi_dreq_s dreq = '0;
  logic bank_pin = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // Observed outputs
  logic [8:0] mem_addr;
  logic mem_rd, mem_wr;
  logic [7:0] mem_wdata, mem_rdata, exec_rdata, reg_rdata;
  logic [12:0] pc;
  // Counters and reference state
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [12:0] pcx = 13'h0000;
  logic [12:0] stk [8];
  logic [2:0] sp = 3'h0;
  logic [7:0] lat = 8'h00;
  logic [7:0] rv;
  always #2 core_clk = ~core_clk;
  pcsi_core DUT (.core_clk(core_clk), .rst_n(rst_n), .flow(flow), .dreq(dreq), .bank_pin(bank_pin),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .exec_rdata(exec_rdata), .pc(pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pcsi_dmem_model MEM (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // Verdict and end of run
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Software register write, one strobe cycle
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk); reg_wr <= 1'b0;
  endtask
  // Software register read, data taken in the following cycle
  task automatic rreg(input logic [2:0] a);
    @(posedge core_clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk); reg_rd <= 1'b0;
    @(negedge core_clk); rv = reg_rdata;
  endtask
  // One flow operation; returns need an idle cycle before the new pc shows
  task automatic flw(input pcsi_pkg::pcsi_op_e o, input logic [10:0] t, input logic [12:0] v);
    logic ret;
    ret = o inside {pcsi_pkg::PCSI_OP_RETURN, pcsi_pkg::PCSI_OP_RET_LIT, pcsi_pkg::PCSI_OP_RET_INT};
    @(posedge core_clk); flow <= '{op: o, target: t, vector: v};
    @(posedge core_clk); flow.op <= pcsi_pkg::PCSI_OP_NONE;
    if (ret) @(posedge core_clk);
    @(negedge core_clk);
    if (o == pcsi_pkg::PCSI_OP_CALL || o == pcsi_pkg::PCSI_OP_IRQ) begin
      stk[sp] = pcx + 13'h0001;
      sp = sp + 3'h1;
    end
    if (o == pcsi_pkg::PCSI_OP_CALL || o == pcsi_pkg::PCSI_OP_JUMP) pcx = {lat[4:3], t};
    if (o == pcsi_pkg::PCSI_OP_IRQ) pcx = v;
    if (o == pcsi_pkg::PCSI_OP_STEP) pcx = pcx + 13'h0001;
    if (ret) begin
      sp = sp - 3'h1;
      pcx = stk[sp];
    end
    `CHK("pc", pcx, pc)
  endtask
  // Data access; ew is the strobe expected at memory, then returned data
  task automatic dacc(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [8:0] ea, input logic ew, input logic [7:0] er);
    @(posedge core_clk); dreq <= '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge core_clk); dreq <= '0;
    @(negedge core_clk);
    `CHK("mem_wr", wr & ew, mem_wr)
    `CHK("mem_rd", rd & ew, mem_rd)
    if (ew) `CHK("mem_addr", ea, mem_addr)
    if (wr && ew) `CHK("mem_wdata", d, mem_wdata)
    @(negedge core_clk);
    if (rd) `CHK("exec_rdata", er, exec_rdata)
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      wrap_up;
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK("pc", 13'h0000, pc)
    rreg(`PCSI_REG_PC_LOW);
    `CHK("pc_low", 8'h00, rv)
    wreg(`PCSI_REG_LATCH, 8'h1f);
    lat = 8'h1f;
    wreg(`PCSI_REG_PC_LOW, 8'h34);
    @(negedge core_clk);
    pcx = 13'h1f34;
    `CHK("pc", pcx, pc)
    rreg(`PCSI_REG_PC_LOW);
    `CHK("pc_low", 8'h34, rv)
    flw(pcsi_pkg::PCSI_OP_JUMP, 11'h5aa, 13'h0000);
    wreg(`PCSI_REG_LATCH, 8'h0a);
    lat = 8'h0a;
    // Nine calls wrap the stack, nine returns show the overwrite
    for (int i = 0; i < 9; i++) flw(pcsi_pkg::PCSI_OP_CALL, 11'h100 + 11'(i * 3), 13'h0000);
    for (int i = 0; i < 9; i++) flw(pcsi_pkg::pcsi_op_e'(3'h4 + 3'(i % 3)), 11'h000, 13'h0000);
    flw(pcsi_pkg::PCSI_OP_IRQ, 11'h000, 13'h0abc);
    flw(pcsi_pkg::PCSI_OP_RET_INT, 11'h000, 13'h0000);
    rreg(`PCSI_REG_LATCH);
    `CHK("latch", 8'h0a, rv)
    // Upper counter bits stay hidden behind the status offset
    rreg(`PCSI_REG_PC_HIGH_STAT);
    `CHK("status", 8'h00, rv)
    // Table jump across a low-byte rollover: software bumps the latch itself
    wreg(`PCSI_REG_PC_LOW, 8'hff);
    @(negedge core_clk);
    pcx = 13'h0aff;
    `CHK("pc", pcx, pc)
    flw(pcsi_pkg::PCSI_OP_STEP, 11'h000, 13'h0000);
    wreg(`PCSI_REG_PC_LOW, 8'h05);
    @(negedge core_clk);
    `CHK("pc", 13'h0a05, pc)
    wreg(`PCSI_REG_LATCH, 8'h0b);
    wreg(`PCSI_REG_PC_LOW, 8'h05);
    @(negedge core_clk);
    lat = 8'h0b;
    pcx = 13'h0b05;
    `CHK("pc", pcx, pc)
    // Call followed at once by a return
    @(posedge core_clk); flow <= '{op: pcsi_pkg::PCSI_OP_CALL, target: 11'h321, vector: 13'h0000};
    @(posedge core_clk); flow.op <= pcsi_pkg::PCSI_OP_RETURN;
    @(posedge core_clk); flow.op <= pcsi_pkg::PCSI_OP_NONE;
    @(posedge core_clk);
    @(negedge core_clk);
    stk[sp] = pcx + 13'h0001;
    pcx = pcx + 13'h0001;
    `CHK("pc", pcx, pc)
    // Stack depth and pointer have no register presence
    for (int a = 5; a < 8; a++) begin
      wreg(3'(a), 8'hff);
      rreg(3'(a));
      `CHK("unmapped", 8'h00, rv)
    end
    // Direct data access bypasses the pointer
    dacc(1'b0, 1'b1, 8'h45, 8'h3c, 9'h045, 1'b1, 8'h00);
    dacc(1'b1, 1'b0, 8'h45, 8'h00, 9'h045, 1'b1, 8'h3c);
    // Indirect access through pointer and bank bit
    wreg(`PCSI_REG_PTR, 8'h20);
    wreg(`PCSI_REG_BANK, 8'h01);
    dacc(1'b0, 1'b1, `PCSI_WINDOW_ADDR, 8'h5c, 9'h120, 1'b1, 8'h00);
    dacc(1'b1, 1'b0, `PCSI_WINDOW_ADDR, 8'h00, 9'h120, 1'b1, 8'h5c);
    wreg(`PCSI_REG_BANK, 8'h00);
    @(posedge core_clk); bank_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rreg(`PCSI_REG_BANK);
    `CHK("bank", 8'h01, rv)
    dacc(1'b0, 1'b1, `PCSI_WINDOW_ADDR, 8'h77, 9'h120, 1'b1, 8'h00);
    @(posedge core_clk); bank_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    dacc(1'b0, 1'b1, `PCSI_WINDOW_ADDR, 8'h66, 9'h020, 1'b1, 8'h00);
    // Window through itself
    wreg(`PCSI_REG_PTR, 8'h00);
    dacc(1'b0, 1'b1, `PCSI_WINDOW_ADDR, 8'h99, 9'h000, 1'b0, 8'h00);
    dacc(1'b1, 1'b0, `PCSI_WINDOW_ADDR, 8'h00, 9'h000, 1'b0, 8'h00);
    // Reset in mid-run, then the block must work from a clean state
    @(posedge core_clk); rst_n <= 1'b0;
    @(negedge core_clk);
    `CHK("pc", 13'h0000, pc)
    @(posedge core_clk); rst_n <= 1'b1;
    pcx = 13'h0000;
    sp = 3'h0;
    lat = 8'h00;
    @(negedge core_clk);
    `CHK("pc", pcx, pc)
    rreg(`PCSI_REG_LATCH);
    `CHK("latch", 8'h00, rv)
    flw(pcsi_pkg::PCSI_OP_STEP, 11'h000, 13'h0000);
    wrap_up;
  end
endmodule
